// *** verilog/switching_threshold_monitor.sv ***
// top: two switching threshold monitors with APB register access
`timescale 1ns/10ps
// Function
// - two independent monitor instances, each with its own configuration registers
// - type off: no outputs, but the compare still runs and shows in the status raw bit
// - on-with-error: met condition raises error
// - on-without-error: met condition raises status only
// - compare one of six selectable sources
// - function picks less-than or more-than activation
// - selection change reloads threshold default
// - both edges delayed 0..10000 ms
module switching_threshold_monitor #(
   parameter int DW = 16,
   parameter int TICK_CYCLES = thr_mon_pkg::TICK_CYCLES,
   parameter logic [15:0] THRESH_DEFAULT = 16'h0000
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [DW-1:0] cmd_in1,
   input wire logic [DW-1:0] cmd_in2,
   input wire logic [DW-1:0] cmd_scaled,
   input wire logic [DW-1:0] fb_in1,
   input wire logic [DW-1:0] fb_in2,
   input wire logic [DW-1:0] fb_scaled,
   output logic [1:0] mon_error,
   output logic [1:0] mon_status
);
   // elaboration-time refusal of widths the register map cannot carry
   if (DW != 16 || TICK_CYCLES < 1)
   begin : bad_params
      $error("unsupported parameter values");
   end

   // ----------------------------------------
   // millisecond tick
   // ----------------------------------------
   logic [31:0] tick_cnt_reg, tick_cnt_next;
   logic tick;
   always_comb
   begin
      tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt_reg <= 32'h0000_0000;
      else
         tick_cnt_reg <= tick_cnt_next;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [1:0] type_reg [2], type_next [2];
   logic [2:0] sel_reg [2], sel_next [2];
   logic func_reg [2], func_next [2];
   logic [DW-1:0] thr_reg [2], thr_next [2];
   logic [13:0] dly_reg [2], dly_next [2];
   logic [13:0] cnt_reg [2], cnt_next [2];
   logic out_reg [2], out_next [2];
   logic raw [2];
   logic [DW-1:0] src_val [2];
   logic [31:0] rdata_next;
   logic wr_en, rd_en, hit;
   logic inst;
   logic [11:0] ofs;

   always_comb
   begin
      wr_en = psel && penable && pwrite;
      // read word is fetched in the setup cycle; pready never waits
      rd_en = psel && !penable && !pwrite;
      inst = paddr[4];
      ofs = paddr & 12'h00F;
      hit = (paddr[11:5] == 7'h00);
      rdata_next = 32'h0000_0000;
      if (!hit)
         rdata_next = 32'h0000_0000;
      else if (ofs == thr_mon_pkg::OFS_CTRL)
         rdata_next = {23'h000000, func_reg[inst], 1'b0, sel_reg[inst], 2'h0, type_reg[inst]};
      else if (ofs == thr_mon_pkg::OFS_THRESH)
         rdata_next = {16'h0000, thr_reg[inst]};
      else if (ofs == thr_mon_pkg::OFS_DELAY)
         rdata_next = {18'h00000, dly_reg[inst]};
      else
         rdata_next = {29'h00000000, raw[inst], mon_status[inst], mon_error[inst]};
   end

   // ----------------------------------------
   // per-instance configuration
   // ----------------------------------------
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         type_next[i] = type_reg[i];
         sel_next[i] = sel_reg[i];
         func_next[i] = func_reg[i];
         thr_next[i] = thr_reg[i];
         dly_next[i] = dly_reg[i];
         if (wr_en && hit && inst == 1'(i))
         begin
            if (ofs == thr_mon_pkg::OFS_CTRL)
            begin
               type_next[i] = pwdata[thr_mon_pkg::CTRL_TYPE_LSB +: 2];
               sel_next[i] = pwdata[thr_mon_pkg::CTRL_SEL_LSB +: 3];
               func_next[i] = pwdata[thr_mon_pkg::CTRL_FUNC_BIT];
               if (pwdata[thr_mon_pkg::CTRL_SEL_LSB +: 3] != sel_reg[i])
                  thr_next[i] = THRESH_DEFAULT;
            end
            else if (ofs == thr_mon_pkg::OFS_THRESH)
               thr_next[i] = pwdata[DW-1:0];
            else if (ofs == thr_mon_pkg::OFS_DELAY)
               // clamp to the longest delay
               dly_next[i] = (pwdata[31:0] > 32'(thr_mon_pkg::DELAY_MAX_MS)) ?
                  14'(thr_mon_pkg::DELAY_MAX_MS) : pwdata[13:0];
         end
      end
   end

   // ----------------------------------------
   // source compare and delay
   // ----------------------------------------
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         // unused source codes compare as zero
         case (sel_reg[i])
            thr_mon_pkg::SRC_CMD1: src_val[i] = cmd_in1;
            thr_mon_pkg::SRC_CMD2: src_val[i] = cmd_in2;
            thr_mon_pkg::SRC_CMD_SCALED: src_val[i] = cmd_scaled;
            thr_mon_pkg::SRC_FB1: src_val[i] = fb_in1;
            thr_mon_pkg::SRC_FB2: src_val[i] = fb_in2;
            thr_mon_pkg::SRC_FB_SCALED: src_val[i] = fb_scaled;
            default: src_val[i] = '0;
         endcase
         // signed values: scaled positions may go negative
         raw[i] = func_reg[i] ? ($signed(src_val[i]) > $signed(thr_reg[i])) :
            ($signed(src_val[i]) < $signed(thr_reg[i]));
         cnt_next[i] = cnt_reg[i];
         out_next[i] = out_reg[i];
         if (type_reg[i] == thr_mon_pkg::TYPE_OFF)
         begin
            cnt_next[i] = 14'h0000;
            out_next[i] = 1'b0;
         end
         else if (raw[i] == out_reg[i])
            cnt_next[i] = 14'h0000;
         // the first tick may come at once, so a full delay needs one tick more
         else if (dly_reg[i] == 14'h0000 || cnt_reg[i] > dly_reg[i])
         begin
            out_next[i] = raw[i];
            cnt_next[i] = 14'h0000;
         end
         else if (tick)
            cnt_next[i] = cnt_reg[i] + 14'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 2; i++)
         begin
            type_reg[i] <= thr_mon_pkg::TYPE_RESET;
            sel_reg[i] <= thr_mon_pkg::SEL_RESET;
            func_reg[i] <= thr_mon_pkg::FUNC_RESET;
            thr_reg[i] <= '0;
            dly_reg[i] <= thr_mon_pkg::DELAY_RESET;
            cnt_reg[i] <= 14'h0000;
            out_reg[i] <= 1'b0;
         end
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            type_reg[i] <= type_next[i];
            sel_reg[i] <= sel_next[i];
            func_reg[i] <= func_next[i];
            thr_reg[i] <= thr_next[i];
            dly_reg[i] <= dly_next[i];
            cnt_reg[i] <= cnt_next[i];
            out_reg[i] <= out_next[i];
         end
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // loaded in the setup cycle so the word stands through the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
         prdata <= rdata_next;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb
   begin
      pready = 1'b1;
      pslverr = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         mon_error[i] = out_reg[i] && (type_reg[i] == thr_mon_pkg::TYPE_ERR);
         mon_status[i] = out_reg[i] && (type_reg[i] == thr_mon_pkg::TYPE_FLAG);
      end
   end
endmodule

// *** verilog/thr_mon_pkg.sv ***
// package: constants, register map and encodings for the switching threshold monitor
package thr_mon_pkg;
   // register offsets (byte addresses), one block of four words per instance
   localparam logic [11:0] INST_STRIDE = 12'h010;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_THRESH = 12'h004;
   localparam logic [11:0] OFS_DELAY = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   // control field positions
   localparam int CTRL_TYPE_LSB = 0;
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_FUNC_BIT = 8;
   // status field positions
   localparam int STAT_ERR_BIT = 0;
   localparam int STAT_FLAG_BIT = 1;
   localparam int STAT_RAW_BIT = 2;
   // reset values
   localparam logic [1:0] TYPE_RESET = 2'h0;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic FUNC_RESET = 1'b0;
   localparam logic [13:0] DELAY_RESET = 14'h0000;
   // timing
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int DELAY_MAX_MS = 10000;
   // monitor type
   typedef enum logic [1:0] {TYPE_OFF = 2'h0, TYPE_ERR = 2'h1, TYPE_FLAG = 2'h2} mon_type_e;
   // monitored source
   typedef enum logic [2:0] {
      SRC_CMD1 = 3'h0, SRC_CMD2 = 3'h1, SRC_CMD_SCALED = 3'h2,
      SRC_FB1 = 3'h3, SRC_FB2 = 3'h4, SRC_FB_SCALED = 3'h5
   } src_e;
endpackage

// *** dv/out_router.sv ***
// partner model: error evaluation and digital output routing
`timescale 1ns/10ps
module out_router (
   input wire logic [1:0] mon_error,
   input wire logic [1:0] mon_status,
   output logic err_out,
   output logic [1:0] sw_out
);
   // any monitor error drives the shared error output
   assign err_out = |mon_error;
   assign sw_out = mon_status;
endmodule

// *** dv/thr_mon_props.sv ***
// checker: port-level properties of the threshold monitor
`timescale 1ns/10ps
module thr_mon_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] mon_error,
   input wire logic [1:0] mon_status
);
   // type shadow; only ctrl writes matter
   logic [1:0] t0_reg;
   logic [1:0] t1_reg;
   logic wr;
   assign wr = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         t0_reg <= 2'h0;
         t1_reg <= 2'h0;
      end
      else if (wr && paddr == 12'h000)
         t0_reg <= pwdata[1:0];
      else if (wr && paddr == 12'h010)
         t1_reg <= pwdata[1:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_high: assert property (pready && !pslverr) else $error("apb answer wrong");
   chk_off_quiet: assert property (t0_reg == 2'h0 |-> !mon_error[0] && !mon_status[0])
      else $error("inst0 off but active");
   chk_off_write: assert property (wr && paddr == 12'h010 && pwdata[1:0] == 2'h0 |=>
      (!mon_error[1] && !mon_status[1]) [*2]) else $error("inst1 off but active");
   chk_err_kind0: assert property (t0_reg != 2'h1 |-> !mon_error[0]) else $error("inst0 bad error");
   chk_err_kind1: assert property (t1_reg != 2'h1 |-> !mon_error[1]) else $error("inst1 bad error");
   chk_flag_kind0: assert property (t0_reg != 2'h2 |-> !mon_status[0]) else $error("inst0 bad flag");
   chk_flag_kind1: assert property (t1_reg != 2'h2 |-> !mon_status[1]) else $error("inst1 bad flag");
   // type may switch while the compare is active, so judge the type now in force
   chk_rise_type: assert property ($rose(mon_status[1]) |-> t1_reg == 2'h2)
      else $error("inst1 flag from wrong type");
   cover property ($rose(mon_error[0]));
   cover property ($fell(mon_error[0]));
   cover property ($rose(mon_status[1]));
endmodule
bind switching_threshold_monitor thr_mon_props u_thr_mon_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .mon_error(mon_error), .mon_status(mon_status));

// *** dv/switching_threshold_monitor_bench.sv ***
// testbench: register sequences and monitor outputs
`timescale 1ns/10ps
module switching_threshold_monitor_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic [15:0] src [6] = '{default: 16'hFFFB};
   logic [1:0] mon_error;
   logic [1:0] mon_status;
   logic err_out;
   logic [1:0] sw_out;
   logic [31:0] q;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   always #5 pclk = ~pclk;
   // short tick keeps ms delays cheap to simulate
   switching_threshold_monitor #(.TICK_CYCLES(10)) u_switching_threshold_monitor (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(), .cmd_in1(src[0]), .cmd_in2(src[1]),
      .cmd_scaled(src[2]), .fb_in1(src[3]), .fb_in2(src[4]), .fb_scaled(src[5]),
      .mon_error(mon_error), .mon_status(mon_status));
   out_router u_out_router (.mon_error(mon_error), .mon_status(mon_status), .err_out(err_out),
      .sw_out(sw_out));
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      // read data is taken at the completing edge
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle cycle keeps the next setup out of this time step
      @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         failures++;
         test_done;
      end
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, 12'h000, 32'h0); chk("ctrl0", 32'h0, q);
      // descending order so every pass changes the selection
      for (int s = 5; s >= 0; s--)
      begin
         foreach (src[k]) src[k] <= (k == s) ? 16'h0005 : 16'hFFFB;
         xfer(1'b1, 12'h004, 32'h64);
         xfer(1'b1, 12'h000, 32'h101 | (s << 4));
         xfer(1'b0, 12'h004, 32'h0); chk("thresh0", 32'h0, q[15:0]);
         xfer(1'b0, 12'h00C, 32'h0); chk("status0", 32'h5, q & 32'h7);
      end
      xfer(1'b1, 12'h000, 32'h001);
      xfer(1'b0, 12'h00C, 32'h0); chk("status_less", 32'h0, q & 32'h7);
      src[0] <= 16'hFFFB;
      xfer(1'b1, 12'h000, 32'h000);
      xfer(1'b1, 12'h010, 32'h052);
      xfer(1'b0, 12'h01C, 32'h0); chk("ports", 32'h2, {mon_error, mon_status});
      chk("routed", 32'h2, {err_out, sw_out});
      xfer(1'b1, 12'h010, 32'h000);
      chk("off1", 32'h0, mon_status[1]);
      xfer(1'b1, 12'h008, 32'h3FFF);
      xfer(1'b0, 12'h008, 32'h0); chk("delay_clamp", 32'h2710, q);
      xfer(1'b1, 12'h008, 32'h3);
      xfer(1'b1, 12'h000, 32'h101);
      src[0] <= 16'h0005;
      repeat (25) @(posedge pclk);
      chk("early", 32'h0, mon_error[0]);
      repeat (20) @(posedge pclk);
      chk("late", 32'h1, mon_error[0]);
      chk("routed_err", 32'h1, err_out);
      // a 2.5 ms and a 3 ms stretch split by one cycle: only a restarted count holds
      src[0] <= 16'hFFFB;
      repeat (25) @(posedge pclk);
      src[0] <= 16'h0005;
      @(posedge pclk);
      src[0] <= 16'hFFFB;
      repeat (30) @(posedge pclk);
      chk("glitch", 32'h1, mon_error[0]);
      repeat (20) @(posedge pclk);
      chk("fall", 32'h0, mon_error[0]);
      test_done;
   end
endmodule
